// [verilog/actc_top.sv]
// converter control: triggers, active flag, low power handling, apb registers
//
// Contract
// - active flag set at start, cleared at end
// - software trigger starts on control one write
// - hardware trigger starts on input assertion
// - bit five enables automatic compare
// - direction bit selects below or at-or-above
// - result high holds upper four or two
// - unused upper result bits forced to zero while compare is off
// - result updates unless compare not met
// - compare result stores sum with complement
// - high read blocks transfer until low read
// - newer result discarded while blocked
// - eight bit mode has no interlock
// - completion sets flag, enabled irq wakes
// - stop3 without async clock aborts conversion
// - stop3 keeps results, needs new trigger
// - async clock keeps converting in stop3
// - stop3 starts by hardware or continuous
// - stop3 completion sets flag and wakes
// - stop2 disables, registers reset after exit
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/100ps
module actc_top
    import actc_pkg::*;
#(
    parameter int CONV_CNT = CONV_CYCLES  // cycles per conversion
)(
    input  wire logic        clk,        // 100 mhz clock
    input  wire logic        rst,        // async reset, high
    input  wire logic        psel,       // apb select
    input  wire logic        penable,    // apb enable
    input  wire logic        pwrite,     // apb direction
    input  wire logic [7:0]  paddr,      // apb byte address
    input  wire logic [31:0] pwdata,     // apb write data
    output logic [31:0]      prdata,     // apb read data
    output logic             pready,     // apb ready
    output logic             pslverr,    // apb error
    input  wire logic        hw_trigger_input, // hardware trigger pin
    input  wire logic [11:0] sample_in,  // analog core sample value
    input  wire logic        stop3,      // stop3 mode level
    input  wire logic        stop2,      // stop2 mode level
    output logic             irq         // conversion complete interrupt
);
    // the timer is 16 bits wide and a zero count would never complete
    if (CONV_CNT < 1 || CONV_CNT > 65535) begin : g_bad_cnt
        $error("actc_top: CONV_CNT out of range");
    end

    typedef enum logic [0:0] {ACTC_IDLE, ACTC_CONV} actc_state_e;

    actc_res_if rif ();

    actc_state_e state_reg;
    actc_state_e state_next;
    logic [15:0] cnt_reg;
    logic [7:0]  sc1_reg;
    logic [7:0]  sc2_reg;
    logic [7:0]  cfg_reg;
    logic [11:0] cv_reg;
    logic [31:0] prdata_reg;
    logic [1:0]  trg_sync_reg;
    logic        trg_prev_reg;
    logic [1:0]  s3_sync_reg;
    logic [1:0]  s2_sync_reg;
    logic        s2_prev_reg;
    logic        clr_pending_reg;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers, first stage read only by second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trg_sync_reg <= 2'b00;
            s3_sync_reg  <= 2'b00;
            s2_sync_reg  <= 2'b00;
        end else begin
            trg_sync_reg <= {trg_sync_reg[0], hw_trigger_input};
            s3_sync_reg  <= {s3_sync_reg[0], stop3};
            s2_sync_reg  <= {s2_sync_reg[0], stop2};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trg_prev_reg <= 1'b0;
            s2_prev_reg  <= 1'b0;
        end else begin
            trg_prev_reg <= trg_sync_reg[1];
            s2_prev_reg  <= s2_sync_reg[1];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // decode
    wire        in_stop3  = s3_sync_reg[1];
    wire        in_stop2  = s2_sync_reg[1];
    // stop2 exit leaves every mapped register at reset value; the timer and read data flops keep theirs
    wire        s2_exit   = s2_prev_reg && !in_stop2;
    wire        async_clk = cfg_reg[CFG_ACK_BIT];
    wire [1:0]  mode      = cfg_reg[CFG_MODE_LSB +: 2];
    wire        cont_en   = sc1_reg[SC1_CONT_BIT];
    wire        hw_sel    = sc2_reg[SC2_TRG_BIT];
    wire        wr_en     = psel && penable && pwrite;
    wire        rd_en     = psel && penable && !pwrite;
    wire        wr_sc1    = wr_en && (paddr == ADDR_SC1);
    wire        wr_sc2    = wr_en && (paddr == ADDR_SC2);
    wire        wr_cvh    = wr_en && (paddr == ADDR_CV_HI);
    wire        wr_cvl    = wr_en && (paddr == ADDR_CV_LO);
    wire        wr_cfg    = wr_en && (paddr == ADDR_CFG);
    wire        rd_sc1    = rd_en && (paddr == ADDR_SC1);
    wire        mapped    = (paddr == ADDR_SC1) || (paddr == ADDR_SC2) || (paddr == ADDR_RES_HI)
                            || (paddr == ADDR_RES_LO) || (paddr == ADDR_CV_HI)
                            || (paddr == ADDR_CV_LO) || (paddr == ADDR_CFG);
    wire        hw_edge   = trg_sync_reg[1] && !trg_prev_reg;
    // clocked stop3 freezes the core, only the async clock keeps it alive
    wire        halted    = (in_stop3 && !async_clk) || in_stop2;
    wire        sw_start  = wr_sc1 && !hw_sel && !in_stop3;
    wire        hw_start  = hw_sel && hw_edge;
    wire        done      = (state_reg == ACTC_CONV) && (cnt_reg == 16'h0001) && !halted;
    wire        cont_go   = cont_en && done;
    wire        start     = (sw_start || hw_start || cont_go) && !halted;
    wire        clr       = s2_exit;

    assign rif.done    = done;
    assign rif.raw     = sample_in;
    // high read locks at its setup edge, where its data is captured
    assign rif.hi_read = psel && !penable && !pwrite && (paddr == ADDR_RES_HI);
    assign rif.lo_read = rd_en && (paddr == ADDR_RES_LO);

    ////////////////////////////////////////////////////////////////////
    // result stage
    actc_result u_result (
        .clk     (clk),
        .rst     (rst),
        .clr     (clr),
        .mode    (mode),
        .cmp_en  (sc2_reg[SC2_CFE_BIT]),
        .cmp_gt  (sc2_reg[SC2_CFGT_BIT]),
        .cmp_val (cv_reg),
        .rif     (rif),
        .stored  ()
    );

    ////////////////////////////////////////////////////////////////////
    // sequencer next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ACTC_IDLE: begin
                if (start) state_next = ACTC_CONV;
            end
            ACTC_CONV: begin
                if (halted) state_next = ACTC_IDLE;
                else if (done) state_next = cont_go ? ACTC_CONV : ACTC_IDLE;
            end
            default: state_next = ACTC_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= ACTC_IDLE;
        end else if (clr) begin
            state_reg <= ACTC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // conversion timer reloads at every start
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 16'h0000;
        end else if (start) begin
            cnt_reg <= 16'(CONV_CNT);
        end else if (state_reg == ACTC_CONV && cnt_reg != 16'h0000) begin
            cnt_reg <= cnt_reg - 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // status control one: complete flag set beats clear by read or write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sc1_reg <= SC1_RESET;
        end else if (clr) begin
            sc1_reg <= SC1_RESET;
        end else begin
            if (wr_sc1) sc1_reg[6:0] <= pwdata[6:0];
            if (done) sc1_reg[SC1_CONVERSION_COMPLETE_FLAG_BIT] <= 1'b1;
            else if (wr_sc1 || clr_pending_reg) sc1_reg[SC1_CONVERSION_COMPLETE_FLAG_BIT] <= 1'b0;
        end
    end

    // a read clears the complete flag only if the captured read data showed it set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clr_pending_reg <= 1'b0;
        end else begin
            clr_pending_reg <= rd_sc1 && prdata_reg[SC1_CONVERSION_COMPLETE_FLAG_BIT];
        end
    end

    // status control two: active bit follows the sequencer, writes ignored there
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sc2_reg <= SC2_RESET;
        end else if (clr) begin
            sc2_reg <= SC2_RESET;
        end else begin
            if (wr_sc2) sc2_reg[6:0] <= pwdata[6:0];
            sc2_reg[SC2_ACT_BIT] <= (state_next == ACTC_CONV);
        end
    end

    // compare value and configuration
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cv_reg  <= 12'h000;
            cfg_reg <= CFG_RESET;
        end else if (clr) begin
            cv_reg  <= 12'h000;
            cfg_reg <= CFG_RESET;
        end else begin
            if (wr_cvh) cv_reg[11:8] <= pwdata[3:0];
            if (wr_cvl) cv_reg[7:0]  <= pwdata[7:0];
            if (wr_cfg) cfg_reg      <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux, registered so data comes from flops
    wire [7:0] rd_byte =
        (paddr == ADDR_SC1)    ? sc1_reg :
        (paddr == ADDR_SC2)    ? sc2_reg :
        (paddr == ADDR_RES_HI) ? {4'h0, rif.result[11:8]} :
        (paddr == ADDR_RES_LO) ? rif.result[7:0] :
        (paddr == ADDR_CV_HI)  ? {4'h0, cv_reg[11:8]} :
        (paddr == ADDR_CV_LO)  ? cv_reg[7:0] :
        (paddr == ADDR_CFG)    ? cfg_reg : 8'h00;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_reg <= {24'h00_0000, rd_byte};
        end
    end

    // zero wait state slave; unmapped addresses answer with error
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = prdata_reg;
    // interrupt wakes from wait or stop3 while enabled
    assign irq     = sc1_reg[SC1_CONVERSION_COMPLETE_FLAG_BIT] && sc1_reg[SC1_COMPLETE_IRQ_ENABLE_BIT];
endmodule // actc_top

// [inc/actc_pkg.sv]
// package of register map, fields and timing for the converter control block
package actc_pkg;
    // register byte offsets (word aligned on apb)
    localparam logic [7:0] ADDR_SC1     = 8'h00;
    localparam logic [7:0] ADDR_SC2     = 8'h04;
    localparam logic [7:0] ADDR_RES_HI  = 8'h08;
    localparam logic [7:0] ADDR_RES_LO  = 8'h0C;
    localparam logic [7:0] ADDR_CV_HI   = 8'h10;
    localparam logic [7:0] ADDR_CV_LO   = 8'h14;
    localparam logic [7:0] ADDR_CFG     = 8'h18;
    // status_control_one fields
    localparam int SC1_CONVERSION_COMPLETE_FLAG_BIT  = 7;
    localparam int SC1_COMPLETE_IRQ_ENABLE_BIT  = 6;
    localparam int SC1_CONT_BIT  = 5;
    // status_control_two fields
    localparam int SC2_ACT_BIT   = 7;
    localparam int SC2_TRG_BIT   = 6;
    localparam int SC2_CFE_BIT   = 5;
    localparam int SC2_CFGT_BIT  = 4;
    // configuration fields
    localparam int CFG_MODE_LSB  = 2;
    localparam int CFG_ACK_BIT   = 0;
    // conversion mode encodings
    localparam logic [1:0] MODE_8BIT  = 2'h0;
    localparam logic [1:0] MODE_12BIT = 2'h1;
    localparam logic [1:0] MODE_10BIT = 2'h2;
    // reset values
    localparam logic [7:0] SC1_RESET  = 8'h1F;
    localparam logic [7:0] SC2_RESET  = 8'h00;
    localparam logic [7:0] CFG_RESET  = 8'h00;
    // conversion time
    localparam int CLK_MHZ       = 100;
    localparam int CONV_TIME_NS  = 230;
    localparam int CONV_CYCLES   = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
endpackage

// [inc/actc_res_if.sv]
// interface carrying conversion results between the sequencer and result stage
`timescale 1ns/100ps
interface actc_res_if;
    logic        done;     // conversion completed, one cycle
    logic [11:0] raw;      // raw sampled value
    logic        hi_read;  // result high read strobe
    logic        lo_read;  // result low read strobe
    logic [11:0] result;   // held result
    modport seq (output done, output raw, output hi_read, output lo_read, input result);
    modport res (input done, input raw, input hi_read, input lo_read, output result);
endinterface

// [verilog/actc_result.sv]
// result stage: formatting, compare and read interlock
`timescale 1ns/100ps
module actc_result
    import actc_pkg::*;
(
    input  wire logic        clk,      // system clock
    input  wire logic        rst,      // async reset, high
    input  wire logic        clr,      // synchronous reset of the stage
    input  wire logic [1:0]  mode,     // resolution mode
    input  wire logic        cmp_en,   // compare enable
    input  wire logic        cmp_gt,   // compare direction
    input  wire logic [11:0] cmp_val,  // compare value
    actc_res_if.res          rif,      // result channel
    output logic             stored    // pulse: result stored
);
    logic [11:0] res_reg;
    logic        lock_reg;
    logic [11:0] fmt;
    logic        cmp_hit;
    logic        interlock;
    logic        accept;

    ////////////////////////////////////////////////////////////////////
    // formatting masks the unused upper bits
    assign fmt = (mode == MODE_8BIT)  ? {4'h0, rif.raw[7:0]} :
                 (mode == MODE_10BIT) ? {2'h0, rif.raw[9:0]} : rif.raw;
    assign cmp_hit   = cmp_gt ? (fmt >= cmp_val) : (fmt < cmp_val);
    assign interlock = (mode != MODE_8BIT);
    // a held lock drops the newer result rather than corrupting a split read
    // a completion at the high read's capture edge is dropped as well
    assign accept    = rif.done && !(interlock && (lock_reg || rif.hi_read))
                       && (!cmp_en || cmp_hit);
    assign stored    = accept;
    assign rif.result = res_reg;

    ////////////////////////////////////////////////////////////////////
    // result register, sum with two's complement on compare
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            res_reg <= 12'h000;
        end else if (clr) begin
            res_reg <= 12'h000;
        end else if (accept) begin
            res_reg <= cmp_en ? 12'(fmt + (~cmp_val) + 12'h001) : fmt;
        end
    end

    // high read locks, low read releases
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_reg <= 1'b0;
        end else if (clr || rif.lo_read || !interlock) begin
            lock_reg <= 1'b0;
        end else if (rif.hi_read) begin
            lock_reg <= 1'b1;
        end
    end
endmodule // actc_result

// [tb/actc_assertions.sv]
// port-level checker for the converter control block
`timescale 1ns/100ps
module actc_assertions
    import actc_pkg::*;
(
    input wire logic        clk,     // clock
    input wire logic        rst,     // async reset, high
    input wire logic        psel,    // apb select
    input wire logic        penable, // apb enable
    input wire logic        pwrite,  // apb direction
    input wire logic [7:0]  paddr,   // apb address
    input wire logic [31:0] pwdata,  // apb write data
    input wire logic [31:0] prdata,  // apb read data
    input wire logic        pready,  // apb ready
    input wire logic        pslverr, // apb error
    input wire logic        stop2,   // stop2 level
    input wire logic        irq      // completion interrupt
);
    // access phase and decode of holes in the map
    wire acc = psel && penable;
    wire unm = paddr[1:0] != 2'h0 || paddr > ADDR_CFG;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    chk_ready_high: assert property (pready) else $error("pready low");
    chk_err_unmapped: assert property (acc && unm |-> pslverr) else $error("no error on hole");
    chk_zero_unmapped: assert property (acc && !pwrite && unm |-> prdata == 32'h0000_0000)
        else $error("hole read not zero");
    chk_high_nibble: assert property (acc && !pwrite && paddr == ADDR_RES_HI |-> prdata[31:4] == 0)
        else $error("result high too wide");
    chk_data_held: assert property (acc && !pwrite ##1 !psel |-> $stable(prdata))
        else $error("read data moved");
    chk_irq_drop: assert property (acc && pwrite && paddr == ADDR_SC1 && !pwdata[SC1_COMPLETE_IRQ_ENABLE_BIT] |=> !irq)
        else $error("irq kept after disable");
    chk_stop2_clear: assert property ($fell(stop2) |-> ##6 !irq)
        else $error("irq after stop2 exit");
    // reset itself must hold outputs quiet, so no disable here
    chk_rst_quiet: assert property (disable iff (1'b0) rst |-> !irq && prdata == 32'h0000_0000)
        else $error("outputs busy in reset");
endmodule // actc_assertions

// [tb/actc_partner.sv]
// trigger source and analog level beside the converter
`timescale 1ns/100ps
module actc_partner (
    input  wire logic        clk,              // clock
    input  wire logic        fire,             // request a trigger pulse
    input  wire logic [11:0] value,            // level to present
    output logic             hw_trigger_input, // trigger pin
    output logic [11:0]      sample_in         // sampled level
);
    logic [1:0] hold_reg = 2'h0; // pulse stretch
    // stretched so the two-flop synchroniser cannot miss it
    always_ff @(posedge clk) begin
        if (fire) hold_reg <= 2'h3;
        else if (hold_reg != 2'h0) hold_reg <= hold_reg - 2'h1;
    end
    assign hw_trigger_input = fire || hold_reg != 2'h0;
    assign sample_in        = value;
endmodule // actc_partner

// [tb/tb.sv]
// self-checking bench for the converter control block
`timescale 1ns/100ps
module tb;
    import actc_pkg::*;
    localparam int CNT = 8; // shortened conversion count
    logic        clk = 0, rst = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00, q;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic        pready, pslverr, irq, hwt, stop3 = 0, stop2 = 0, fire = 0, qe;
    logic [11:0] value = 12'h000, smp;
    int          num_errors = 0, tests_run = 0, cyc = 0;
    always #5 clk = ~clk;
    actc_top #(.CONV_CNT(CNT)) i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hw_trigger_input(hwt), .sample_in(smp), .stop3(stop3), .stop2(stop2), .irq(irq));
    actc_partner i_src (.clk(clk), .fire(fire), .value(value), .hw_trigger_input(hwt), .sample_in(smp));
    ////////////////////////////////////////
    // apb master: holds the request until pready is seen high
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata[7:0];
        qe = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
        bus(a, 1'b0, 8'h00);
        chk(n, e, q);
    endtask
    // software start and a wait long enough for one conversion
    task automatic conv(input logic [11:0] v, input logic [7:0] c);
        value <= v;
        bus(ADDR_SC1, 1'b1, c);
        repeat (CNT + 4) @(posedge clk);
    endtask
    task automatic pulse();
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    ////////////////////////////////////////
    task automatic t_regs();
        rd("sc1", ADDR_SC1, SC1_RESET);
        rd("sc2", ADDR_SC2, SC2_RESET);
        rd("cfg", ADDR_CFG, CFG_RESET);
        bus(8'h1C, 1'b1, 8'hFF);
        chk("hole err", 8'h01, {7'h00, qe});
        rd("hole", 8'h1C, 8'h00);
        bus(ADDR_SC2, 1'b1, 8'h80);
        rd("active ro", ADDR_SC2, 8'h00);
        chk("mapped err", 8'h00, {7'h00, qe});
        $display("test regs done");
    endtask
    task automatic t_sw();
        bus(ADDR_CFG, 1'b1, 8'h04);
        value <= 12'hABC;
        bus(ADDR_SC1, 1'b1, 8'h40);
        rd("active", ADDR_SC2, 8'h80);
        repeat (CNT + 4) @(posedge clk);
        chk("irq", 8'h01, {7'h00, irq});
        rd("idle", ADDR_SC2, 8'h00);
        rd("complete", ADDR_SC1, 8'hC0);
        rd("high", ADDR_RES_HI, 8'h0A);
        rd("low", ADDR_RES_LO, 8'hBC);
        $display("test software start done");
    endtask
    task automatic t_modes();
        logic [7:0] hi [2] = '{8'h03, 8'h00};
        logic [1:0] md [2] = '{MODE_10BIT, MODE_8BIT};
        for (int i = 0; i < 2; i++) begin
            bus(ADDR_CFG, 1'b1, {4'h0, md[i], 2'h0});
            conv(12'hFFF, 8'h00);
            rd("mode high", ADDR_RES_HI, hi[i]);
            rd("mode low", ADDR_RES_LO, 8'hFF);
        end
        $display("test modes done");
    endtask
    task automatic t_cmp();
        bus(ADDR_CFG, 1'b1, 8'h04);
        bus(ADDR_CV_HI, 1'b1, 8'h01);
        bus(ADDR_CV_LO, 1'b1, 8'h00);
        bus(ADDR_SC2, 1'b1, 8'h20);
        conv(12'h080, 8'h00);
        rd("below high", ADDR_RES_HI, 8'h0F);
        rd("below low", ADDR_RES_LO, 8'h80);
        conv(12'h200, 8'h00);
        rd("unmet high", ADDR_RES_HI, 8'h0F);
        rd("unmet low", ADDR_RES_LO, 8'h80);
        bus(ADDR_SC2, 1'b1, 8'h30);
        conv(12'h200, 8'h00);
        rd("above low", ADDR_RES_LO, 8'h00);
        bus(ADDR_SC2, 1'b1, 8'h10);
        conv(12'h080, 8'h00);
        rd("off low", ADDR_RES_LO, 8'h80);
        $display("test compare done");
    endtask
    task automatic t_lock();
        conv(12'h123, 8'h00);
        rd("lock high", ADDR_RES_HI, 8'h01);
        conv(12'h456, 8'h00);
        rd("lock low", ADDR_RES_LO, 8'h23);
        rd("kept high", ADDR_RES_HI, 8'h01);
        rd("kept low", ADDR_RES_LO, 8'h23);
        bus(ADDR_CFG, 1'b1, 8'h00);
        conv(12'h0AA, 8'h00);
        rd("free high", ADDR_RES_HI, 8'h00);
        conv(12'h055, 8'h00);
        rd("free low", ADDR_RES_LO, 8'h55);
        $display("test interlock done");
    endtask
    task automatic t_hw();
        bus(ADDR_CFG, 1'b1, 8'h04);
        bus(ADDR_SC2, 1'b1, 8'h40);
        value <= 12'h321;
        bus(ADDR_SC1, 1'b1, 8'h00);
        rd("no sw start", ADDR_SC2, 8'h40);
        pulse();
        rd("hw active", ADDR_SC2, 8'hC0);
        repeat (CNT + 4) @(posedge clk);
        rd("hw low", ADDR_RES_LO, 8'h21);
        $display("test hardware start done");
    endtask
    task automatic t_stop();
        bus(ADDR_SC2, 1'b1, 8'h00);
        value <= 12'h777;
        bus(ADDR_SC1, 1'b1, 8'h00);
        stop3 <= 1'b1;
        repeat (CNT + 4) @(posedge clk);
        rd("aborted", ADDR_SC2, 8'h00);
        rd("kept", ADDR_RES_LO, 8'h21);
        stop3 <= 1'b0;
        repeat (CNT + 4) @(posedge clk);
        rd("no resume", ADDR_SC1, 8'h00);
        bus(ADDR_CFG, 1'b1, 8'h05);
        value <= 12'h5A5;
        bus(ADDR_SC1, 1'b1, 8'h40);
        stop3 <= 1'b1;
        repeat (CNT + 4) @(posedge clk);
        chk("stop3 wake", 8'h01, {7'h00, irq});
        rd("stop3 done", ADDR_SC1, 8'hC0);
        bus(ADDR_SC2, 1'b1, 8'h40);
        value <= 12'h3C3;
        pulse();
        repeat (CNT + 4) @(posedge clk);
        chk("stop3 hw", 8'h01, {7'h00, irq});
        rd("stop3 low", ADDR_RES_LO, 8'hC3);
        stop3 <= 1'b0;
        stop2 <= 1'b1;
        repeat (6) @(posedge clk);
        stop2 <= 1'b0;
        repeat (8) @(posedge clk);
        rd("cfg cleared", ADDR_CFG, CFG_RESET);
        rd("sc1 cleared", ADDR_SC1, SC1_RESET);
        rd("sc2 cleared", ADDR_SC2, SC2_RESET);
        $display("test stop modes done");
    endtask
    ////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // hang guard, well above the few hundred cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end
    initial begin
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_sw();
        t_modes();
        t_cmp();
        t_lock();
        t_hw();
        t_stop();
        report_and_stop();
    end
endmodule // tb
bind actc_top actc_assertions i_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .stop2(stop2), .irq(irq));
